// ===== hdl/msl_pkg.sv
// Shared constants for the MII status and loopback logic
package msl_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h10;
    localparam logic [7:0] ADDR_STAT = 8'h14;

    // Control register fields
    localparam int CTRL_FDX_BIT = 8;
    localparam int CTRL_AN_BIT = 12;
    localparam int CTRL_SPD_BIT = 13;
    localparam int CTRL_TLB_BIT = 14;
    localparam logic [15:0] CTRL_MASK = 16'h7100;
    localparam logic [15:0] CTRL_RST = 16'h3000;

    // Configuration register fields
    localparam int CFG_NOLB_BIT = 8;
    localparam logic [15:0] CFG_MASK = 16'h0100;
    localparam logic [15:0] CFG_RST = 16'h0000;

    // Status register fields
    localparam int STAT_TLB_BIT = 0;
    localparam int STAT_OLB_BIT = 1;
    localparam int STAT_CRS_BIT = 2;
    localparam int STAT_COL_BIT = 3;
    localparam int STAT_OVF_BIT = 4;
    localparam int STAT_LDV_BIT = 5;

    // Nibble driven on receive data for a bad line symbol
    localparam logic [3:0] NIB_ERR = 4'h5;

    // Transmit buffer shape: enable flag above the nibble
    localparam int FIFO_W = 5;
    localparam int FIFO_D = 8;

    // Synchronised input bundle
    localparam int SYNC_W = 13;

endpackage

// ===== hdl/msl_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels
module msl_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } msl_sync_st_t;

    msl_sync_st_t st;
    msl_sync_st_t next_st;

    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
        if (!nrst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

    assign q = st.s2;

endmodule

// ===== hdl/msl_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
module msl_fifo #(
    parameter int W = 5,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW+1)'(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } msl_fifo_st_t;

    msl_fifo_st_t st;
    msl_fifo_st_t next_st;
    logic push;
    logic pop;

    assign in_ready = st.cnt != FULL;
    assign out_valid = st.cnt != '0;
    assign out_data = st.mem[st.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data;
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (!nrst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clk) begin
        st <= next_st;
    end

endmodule

// ===== hdl/msl_core.sv
// MII carrier, collision, receive error and loopback logic of the PHY
// Behaviour
// - Collision asserted whenever half-duplex with transmit and receive both active.
// - At 100 Mbps a bad line symbol raises receive error, data 0101.
// - No transmit error input; line output carries only transmit data.
// - 10 Mbps half-duplex with config bit clear loops transmit onto receive.
// - No operational loopback at 100 Mbps, full-duplex, or config bit set.
// - Test loopback disables twisted-pair and fiber line interfaces.
// - Test loopback returns all transmit data to the MAC internally.
// - Test loopback at both speeds: loopback, full-duplex set, autoneg clear.
// - Carrier on receive, plus transmit in half-duplex; in test loopback carrier follows RX_DV.
// - Transmit enable and data sampled on each rising transmit clock.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
module msl_core (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic TX_CLK,
    input wire logic TX_EN,
    input wire logic [3:0] TXD,
    output logic RX_DV,
    output logic RX_ER,
    output logic [3:0] RXD,
    output logic CRS,
    output logic COL,
    input wire logic LINE_RX_DV,
    input wire logic [3:0] LINE_RXD,
    input wire logic LINE_SYM_ERR,
    input wire logic LINE_TX_READY,
    output logic TWISTED_PAIR_TX_EN,
    output logic [3:0] TWISTED_PAIR_TX_OUT,
    output logic TP_IF_EN,
    output logic FIBER_IF_EN
);

    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] cfg;
        logic [15:0] rdata;
        logic ovf;
        logic tclk_d;
        logic txen_d;
        logic [4:0] tx_prev;
        logic push_v;
        logic [4:0] push_d;
        logic rx_dv;
        logic rx_er;
        logic [3:0] rxd;
        logic tp_en;
        logic [3:0] tp_d;
    } msl_core_st_t;

    msl_core_st_t st;
    msl_core_st_t next_st;

    // Synchronised inputs
    logic [12:0] raw_in;
    logic [12:0] syn_in;
    logic s_tclk;
    logic s_txen;
    logic [3:0] s_txd;
    logic s_ldv;
    logic [3:0] s_lrxd;
    logic s_lerr;
    logic s_lrdy;

    // Mode decode
    logic fdx;
    logic spd100;
    logic test_lb;
    logic op_lb;

    // Link clock edges
    logic tx_rise;
    logic tx_fall;

    // Buffer handshake
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [4:0] fifo_out_data;
    logic pop;
    logic loop_dv;
    logic [3:0] loop_d;

    // Register bus helpers
    logic [15:0] stat_word;
    logic [15:0] rd_word;
    logic wr_stat;

    // Overflow bookkeeping
    logic ovf_clr;
    logic ovf_set;

    // Activity levels behind carrier and collision
    logic tx_active;
    logic rx_active;
    logic half_dx;

    // Transmit capture ahead of the buffer
    logic cap_v;
    logic [4:0] cap_d;

    // Receive source chosen ahead of the link clock edge
    logic rx_sel_dv;
    logic rx_sel_er;
    logic [3:0] rx_sel_d;

    // Line output chosen ahead of the link clock edge
    logic line_dv;
    logic [3:0] line_d;

    assign raw_in = {TX_CLK, TX_EN, TXD, LINE_RX_DV, LINE_RXD,
                     LINE_SYM_ERR, LINE_TX_READY};

    // Every pin from the MAC or line side crosses here first
    msl_sync #(
        .W(msl_pkg::SYNC_W)
    ) u_sync (
        .clk(CLK),
        .nrst(NRST),
        .d(raw_in),
        .q(syn_in)
    );

    assign s_tclk = syn_in[12];
    assign s_txen = syn_in[11];
    assign s_txd = syn_in[10:7];
    assign s_ldv = syn_in[6];
    assign s_lrxd = syn_in[5:2];
    assign s_lerr = syn_in[1];
    assign s_lrdy = syn_in[0];

    assign fdx = st.ctrl[msl_pkg::CTRL_FDX_BIT];
    assign spd100 = st.ctrl[msl_pkg::CTRL_SPD_BIT];

    // Loopback only with full-duplex forced and autoneg off
    assign test_lb = st.ctrl[msl_pkg::CTRL_TLB_BIT] && fdx
                     && !st.ctrl[msl_pkg::CTRL_AN_BIT];

    // Half-duplex, 10 Mbps, config bit clear
    assign op_lb = !test_lb && !spd100 && !fdx
                   && !st.cfg[msl_pkg::CFG_NOLB_BIT];

    assign tx_rise = s_tclk && !st.tclk_d;
    assign tx_fall = !s_tclk && st.tclk_d;

    // Line drains the buffer; in test loopback the line is ignored
    assign fifo_out_ready = tx_fall && (test_lb || s_lrdy);
    assign pop = fifo_out_valid && fifo_out_ready;
    assign loop_dv = pop && fifo_out_data[4];
    assign loop_d = fifo_out_data[3:0];

    msl_fifo #(
        .W(msl_pkg::FIFO_W),
        .D(msl_pkg::FIFO_D)
    ) u_fifo (
        .clk(CLK),
        .nrst(NRST),
        .in_valid(st.push_v),
        .in_ready(fifo_in_ready),
        .in_data(st.push_d),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Synced levels trail the pins by two cycles; no clock edge gates them
    assign tx_active = s_txen;
    assign rx_active = s_ldv;
    assign half_dx = !fdx && !test_lb;

    // Carrier and collision follow the levels, not the link clock, except carrier in test loopback, which follows RX_DV
    always_comb begin
        if (test_lb) begin
            CRS = st.rx_dv;
        end else begin
            CRS = rx_active || (!fdx && tx_active);
        end
    end

    // Only while both sides are busy; drops as soon as either stops
    assign COL = half_dx && tx_active && rx_active;

    // Line side is shut off for the whole of test loopback
    assign TP_IF_EN = !test_lb;
    assign FIBER_IF_EN = !test_lb;

    assign wr_stat = WR && ADDR == msl_pkg::ADDR_STAT;
    assign ovf_clr = wr_stat && WDATA[msl_pkg::STAT_OVF_BIT];
    // MAC cannot be stalled, so a refused nibble is lost
    assign ovf_set = st.push_v && !fifo_in_ready;

    // Status bits placed by name so the map lives in the package
    always_comb begin
        stat_word = 16'h0000;
        stat_word[msl_pkg::STAT_TLB_BIT] = test_lb;
        stat_word[msl_pkg::STAT_OLB_BIT] = op_lb;
        stat_word[msl_pkg::STAT_CRS_BIT] = CRS;
        stat_word[msl_pkg::STAT_COL_BIT] = COL;
        stat_word[msl_pkg::STAT_OVF_BIT] = st.ovf;
        stat_word[msl_pkg::STAT_LDV_BIT] = s_ldv;
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        unique case (ADDR)
            msl_pkg::ADDR_CTRL: begin
                rd_word = st.ctrl;
            end
            msl_pkg::ADDR_CFG: begin
                rd_word = st.cfg;
            end
            msl_pkg::ADDR_STAT: begin
                rd_word = stat_word;
            end
            default: begin
                rd_word = 16'h0000;
            end
        endcase
    end

    // Synced data may already move in the cycle the synced clock
    // rises, so the copy from just before the edge is taken
    always_comb begin
        cap_v = 1'b0;
        cap_d = st.tx_prev;
        if (tx_rise && (st.tx_prev[4] || st.txen_d)) begin
            cap_v = 1'b1;
        end
    end

    // Line coder never sees looped data while test loopback runs
    always_comb begin
        line_dv = loop_dv && !test_lb;
        // Idle nibble is zero so the coder never sees stale data
        line_d = 4'h0;
        if (line_dv) begin
            line_d = loop_d;
        end
    end

    // Receive source priority: test loop, operational loop while the line is idle, error, line
    always_comb begin
        rx_sel_dv = s_ldv;
        rx_sel_er = 1'b0;
        rx_sel_d = s_lrxd;
        if (test_lb) begin
            // Line side is ignored for the whole test
            rx_sel_dv = loop_dv;
            rx_sel_d = loop_d;
        end else if (op_lb && !s_ldv) begin
            // Line reception keeps priority over the local echo
            rx_sel_dv = loop_dv;
            rx_sel_d = loop_d;
        end else if (spd100 && s_ldv && s_lerr) begin
            // Bad symbol replaces the nibble; never at 10 Mbps
            rx_sel_dv = 1'b1;
            rx_sel_er = 1'b1;
            rx_sel_d = msl_pkg::NIB_ERR;
        end
    end

    always_comb begin
        next_st = st;

        // Transmit clock edge tracking
        next_st.tclk_d = s_tclk;
        next_st.tx_prev = {s_txen, s_txd};

        // Closing word with enable low marks the frame end
        if (tx_rise) begin
            next_st.txen_d = st.tx_prev[4];
        end
        next_st.push_v = cap_v;
        if (cap_v) begin
            next_st.push_d = cap_d;
        end

        // Line output carries transmit data alone
        if (tx_fall) begin
            next_st.tp_en = line_dv;
            next_st.tp_d = line_d;
        end

        // Receive side updates on the falling link clock
        if (tx_fall) begin
            next_st.rx_dv = rx_sel_dv;
            next_st.rx_er = rx_sel_er;
            next_st.rxd = rx_sel_d;
        end

        // Overflow is sticky; a new loss beats a clear
        if (ovf_clr) begin
            next_st.ovf = 1'b0;
        end
        if (ovf_set) begin
            next_st.ovf = 1'b1;
        end

        // Register writes
        if (WR) begin
            unique case (ADDR)
                msl_pkg::ADDR_CTRL: begin
                    next_st.ctrl = WDATA & msl_pkg::CTRL_MASK;
                end
                msl_pkg::ADDR_CFG: begin
                    next_st.cfg = WDATA & msl_pkg::CFG_MASK;
                end
                default: begin
                end
            endcase
        end

        // Read data stands for one cycle only
        // Zero between reads keeps the bus quiet
        next_st.rdata = 16'h0000;
        if (RD) begin
            next_st.rdata = rd_word;
        end

        if (!NRST) begin
            next_st = '0;
            next_st.ctrl = msl_pkg::CTRL_RST;
            next_st.cfg = msl_pkg::CFG_RST;
        end
    end

    always_ff @(posedge CLK) begin
        st <= next_st;
    end

    assign RDATA = st.rdata;
    assign RX_DV = st.rx_dv;
    assign RX_ER = st.rx_er;
    assign RXD = st.rxd;
    assign TWISTED_PAIR_TX_EN = st.tp_en;
    assign TWISTED_PAIR_TX_OUT = st.tp_d;

endmodule

// ===== tb/msl_core_assertions.sv
// Checker for collision, carrier, error and line enable behaviour
module msl_core_assertions (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [7:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic TX_EN,
    input wire logic LINE_RX_DV,
    input wire logic RX_DV,
    input wire logic RX_ER,
    input wire logic [3:0] RXD,
    input wire logic CRS,
    input wire logic COL,
    input wire logic TWISTED_PAIR_TX_EN,
    input wire logic TP_IF_EN,
    input wire logic FIBER_IF_EN
);
    logic [15:0] ctrl;
    logic fdx;
    logic tlb;
    logic spd;
    assign fdx = ctrl[8];
    assign spd = ctrl[13];
    assign tlb = ctrl[14] & ctrl[8] & !ctrl[12];
    // Shadow of control, so modes are known without looking inside
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ctrl <= msl_pkg::CTRL_RST;
        end else if (WR && ADDR == msl_pkg::ADDR_CTRL) begin
            ctrl <= WDATA & msl_pkg::CTRL_MASK;
        end
    end
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);
    // Four cycles cover both synchroniser stages
    a_col_both_on: assert property ((!fdx && !tlb && TX_EN && LINE_RX_DV)[*4]
        |-> COL) else $error("collision missing");
    a_col_ends: assert property (((!LINE_RX_DV)[*4] or (!TX_EN)[*4])
        |-> !COL) else $error("collision held");
    a_col_fdx: assert property (fdx || tlb |-> !COL)
        else $error("collision in full duplex");
    a_line_if_off: assert property (TP_IF_EN == !tlb && FIBER_IF_EN == !tlb)
        else $error("line interface enable wrong");
    a_tp_quiet: assert property (tlb && $past(tlb)
        |-> !$rose(TWISTED_PAIR_TX_EN)) else $error("line sent");
    a_er_nibble: assert property (RX_ER |-> RX_DV && RXD == msl_pkg::NIB_ERR)
        else $error("error nibble wrong");
    a_er_slow: assert property (!spd && !$past(spd) |-> !$rose(RX_ER))
        else $error("error at 10 Mbps");
    a_crs_rx: assert property ((!tlb && LINE_RX_DV)[*4] |-> CRS)
        else $error("carrier missing");
    c_col: cover property (COL);
    c_err: cover property (RX_ER);
    c_tlb: cover property (tlb && RX_DV);
endmodule

// ===== tb/msl_mac_model.sv
// Behavioural MAC sending one nibble frame per request
module msl_mac_model (
    input wire logic tx_clk,
    input wire logic start,
    input wire logic [3:0] base,
    input wire logic [4:0] len,
    output logic tx_en,
    output logic [3:0] txd,
    output logic done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] cnt = 5'h0;
    initial begin
        tx_en = 1'b0;
        txd = 4'h0;
        done = 1'b0;
    end
    always @(posedge tx_clk) begin
        if (!start) begin
            cnt <= 5'h0;
        end
        if (start && cnt < len) begin
            tx_en <= 1'b1;
            txd <= base + 4'(cnt);
            cnt <= cnt + 5'h1;
        end else begin
            tx_en <= 1'b0;
            // Idle data toggles so a stale nibble is never mistaken
            txd <= ~txd;
            done <= start;
        end
    end
endmodule

// ===== tb/tb_msl_core.sv
// Self-checking bench for the MII status and loopback logic
module tb_msl_core;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK = 0;
    logic NRST = 0;
    logic [7:0] ADDR = 0;
    logic [15:0] WDATA = 0;
    logic WR = 0;
    logic RD = 0;
    logic TX_CLK = 0;
    logic LINE_RX_DV = 0;
    logic [3:0] LINE_RXD = 0;
    logic LINE_SYM_ERR = 0;
    logic LINE_TX_READY = 1;
    logic start = 0;
    logic [3:0] base = 0;
    logic [4:0] len = 0;
    logic TX_EN, RX_DV, RX_ER, CRS, COL, done;
    logic TWISTED_PAIR_TX_EN, TP_IF_EN, FIBER_IF_EN;
    logic [3:0] TXD, RXD, TWISTED_PAIR_TX_OUT;
    logic [15:0] RDATA, v;
    logic [3:0] rxq[$];
    logic [3:0] lnq[$];
    logic [4:0] rx_prev = 0;
    logic [4:0] ln_prev = 0;
    int seed = 84;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [15:0] mc[7] = '{16'h2000, 16'h6100, 16'h4100, 16'h0000,
        16'h0000, 16'h0100, 16'h5100};
    msl_core u_dut (.CLK, .NRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .TX_CLK,
        .TX_EN, .TXD, .RX_DV, .RX_ER, .RXD, .CRS, .COL, .LINE_RX_DV,
        .LINE_RXD, .LINE_SYM_ERR, .LINE_TX_READY, .TWISTED_PAIR_TX_EN,
        .TWISTED_PAIR_TX_OUT, .TP_IF_EN, .FIBER_IF_EN);
    msl_mac_model u_mac (.tx_clk(TX_CLK), .start, .base, .len,
        .tx_en(TX_EN), .txd(TXD), .done);
    always #12.5 CLK = ~CLK;
    initial begin
        #37;
        forever #100 TX_CLK = ~TX_CLK;
    end
    // Capture nibbles on change; frames use distinct consecutive values
    always @(negedge CLK) begin
        rx_prev <= {RX_DV, RXD};
        ln_prev <= {TWISTED_PAIR_TX_EN, TWISTED_PAIR_TX_OUT};
        if (RX_DV === 1'b1 && {RX_DV, RXD} !== rx_prev) rxq.push_back(RXD);
        if (TWISTED_PAIR_TX_EN === 1'b1 &&
            {TWISTED_PAIR_TX_EN, TWISTED_PAIR_TX_OUT} !== ln_prev)
            lnq.push_back(TWISTED_PAIR_TX_OUT);
        cyc <= cyc + 1;
        // Whole run needs about 1500 cycles
        if (cyc == 40000) begin
            n_fail++;
            wrap_up();
        end
    end
    function automatic logic [1:0] lb(input logic [15:0] c, f);
        logic t;
        t = c[14] & c[8] & !c[12];
        return {!t & !c[13] & !c[8] & !f[8], t};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1 d = RDATA;
    endtask
    task automatic send(input int n);
        @(posedge CLK);
        base <= 4'($random(seed));
        len <= 5'(n);
        start <= 1'b1;
        rxq.delete();
        lnq.delete();
        repeat (28) @(posedge CLK);
        #1;
    endtask
    task automatic fin();
        for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge CLK);
        start <= 1'b0;
        repeat (60) @(posedge CLK);
    endtask
    task automatic cmpq(input logic [3:0] q[$], input int n);
        chk(16'(q.size()), 16'(n));
        foreach (q[i]) chk(16'(q[i]), 16'(4'(base + i)));
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        logic [15:0] r, f;
        logic [1:0] e;
        repeat (8) @(posedge CLK);
        NRST <= 1'b1;
        rd(8'h00, v);
        chk(v, msl_pkg::CTRL_RST);
        r = 16'($random(seed));
        wr(8'h00, r);
        rd(8'h00, v);
        chk(v, r & msl_pkg::CTRL_MASK);
        wr(8'h20, r);
        rd(8'h20, v);
        chk(v, 16'h0000);
        for (int m = 0; m < 7; m++) begin
            f = (m == 4) ? 16'h0100 : 16'h0000;
            e = lb(mc[m], f);
            wr(8'h00, mc[m]);
            wr(8'h10, f);
            rd(8'h14, v);
            chk(v & 16'h0003, {14'h0, e});
            chk(16'(TP_IF_EN), 16'(!e[0]));
            chk(16'(FIBER_IF_EN), 16'(!e[0]));
            send(5 + ($random(seed) & 7));
            chk(16'(CRS), 16'(e[0] | !mc[m][8]));
            fin();
            cmpq(rxq, (e != 0) ? int'(len) : 0);
            cmpq(lnq, e[0] ? 0 : int'(len));
        end
        wr(8'h00, 16'h2000);
        LINE_RX_DV <= 1'b1;
        LINE_SYM_ERR <= 1'b1;
        LINE_RXD <= 4'($random(seed));
        send(8);
        chk(16'(COL), 16'h0001);
        chk({11'h0, RX_ER, RXD}, 16'h0015);
        wr(8'h00, 16'h2100);
        @(posedge CLK);
        #1 chk(16'(COL), 16'h0000);
        fin();
        wr(8'h00, 16'h0000);
        repeat (24) @(posedge CLK);
        #1 chk(16'(RX_ER), 16'h0000);
        LINE_RX_DV <= 1'b0;
        LINE_SYM_ERR <= 1'b0;
        wr(8'h00, 16'h2000);
        LINE_TX_READY <= 1'b0;
        send(12);
        fin();
        rd(8'h14, v);
        chk(v & 16'h0010, 16'h0010);
        LINE_TX_READY <= 1'b1;
        repeat (100) @(posedge CLK);
        cmpq(lnq, 8);
        wr(8'h14, 16'h0010);
        rd(8'h14, v);
        chk(v & 16'h0010, 16'h0000);
        wrap_up();
    end
endmodule
bind msl_core msl_core_assertions u_chk (.CLK, .NRST, .ADDR, .WDATA, .WR,
    .TX_EN, .LINE_RX_DV, .RX_DV, .RX_ER, .RXD, .CRS, .COL,
    .TWISTED_PAIR_TX_EN, .TP_IF_EN, .FIBER_IF_EN);
